// ===== hw/tcp_slave.sv
// Two-wire command packet slave: address match, command/status routing, packet framing.
// Assumes external pull-ups on the bus and a command engine on the exec ports.
`timescale 1ns/100ps
`default_nettype none
module tcp_slave #(
    parameter int START_CYC = tcp_pkg::START_WAIT_CYC,
    parameter int WAKE_CYC = tcp_pkg::WAKE_WAIT_CYC,
    parameter int EXEC_CYC = tcp_pkg::EXEC_MAX_CYC,
    parameter int PENALTY_CYC = tcp_pkg::START_WAIT_CYC
) (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_out,
    input wire logic sleep_request_in,
    input wire logic [7:0] dev_addr_in,
    input wire logic exec_done_in,
    input wire logic [2:0] exec_err_in,
    input wire logic exec_len_err_in,
    output logic [7:0] cmd_out,
    output logic [7:0] count_out,
    output logic exec_start_out,
    output logic output_ready_flag,
    output logic handshake_complete_flag,
    output logic busy_out,
    output logic asleep_out
);
    // ****************************************
    // Input conditioning
    // ****************************************
    logic scl, sda, scl_d, sda_d, slp_s;
    tcp_sync u_scl (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(scl_in), .level_out(scl));
    tcp_sync u_sda (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(sda_in), .level_out(sda));
    tcp_sync u_slp (.mclk_in(mclk_in), .rst_b_in(rst_b_in), .pin_in(sleep_request_in), .level_out(slp_s));
    logic [31:0] hold, next_hold;
    logic [31:0] exec_cnt, next_exec_cnt;
    logic pen, next_pen, exec, next_exec;
    logic [1:0] rst_seen, next_rst_seen;
    wire rise = scl & ~scl_d;
    wire fall = ~scl & scl_d;
    wire start_c = scl & scl_d & sda_d & ~sda;
    wire stop_c = scl & scl_d & ~sda_d & sda;
    wire bus_on = ~slp_s && hold == 32'h0;
    wire busy = exec | pen | (hold != 32'h0);
    // ****************************************
    // Timers: startup, wake, execution, penalty
    // ****************************************
    logic [7:0] cmd, next_cmd, cnt, next_cnt;
    logic go, next_go;
    logic ready, next_ready, hs, next_hs;
    logic [2:0] err, next_err;
    logic exec_done_pulse;
    always_comb begin
        next_hold = (hold != 32'h0) ? hold - 32'h1 : hold;
        next_rst_seen = rst_seen;
        next_pen = pen;
        next_exec = exec;
        next_exec_cnt = exec_cnt;
        exec_done_pulse = 1'b0;
        if (rst_seen == 2'h0) begin
            next_hold = 32'(START_CYC);
            next_rst_seen = 2'h1;
        end
        if (slp_s) begin
            next_hold = 32'(WAKE_CYC);
        end
        if (go && cmd >= tcp_pkg::CMD_ILLEGAL) begin
            next_pen = 1'b1;
            next_exec_cnt = 32'(PENALTY_CYC);
        end else if (go) begin
            next_exec = 1'b1;
            next_exec_cnt = 32'(EXEC_CYC);
        end else if (exec_cnt != 32'h0) begin
            next_exec_cnt = exec_cnt - 32'h1;
        end
        if (pen && exec_cnt == 32'h0) begin
            next_pen = 1'b0;
        end
        if (exec && (exec_done_in || exec_cnt == 32'h0)) begin
            next_exec = 1'b0;
            exec_done_pulse = 1'b1;
        end
    end
    // ****************************************
    // Byte engine
    // ****************************************
    tcp_pkg::tcp_state_type st, next_st;
    logic [7:0] sh, next_sh;
    logic [3:0] bit_n, next_bit_n;
    logic [8:0] idx, next_idx;
    logic rd, next_rd, stat, next_stat, ack, next_ack, o_sda, next_o_sda;
    logic [7:0] buf_mem [tcp_pkg::BUF_DEPTH];
    logic wr_en;
    logic [7:0] wr_addr;
    wire [7:0] status = {err, 2'h0, hs, busy, ready};
    wire [7:0] tx_byte = stat ? status : (idx == 9'h0 ? cnt : buf_mem[idx[7:0] - 8'h1]);
    always_comb begin
        next_st = st;
        next_sh = sh;
        next_bit_n = bit_n;
        next_idx = idx;
        next_rd = rd;
        next_stat = stat;
        next_ack = ack;
        next_o_sda = o_sda;
        next_cmd = cmd;
        next_cnt = cnt;
        next_go = 1'b0;
        next_ready = ready;
        next_hs = hs;
        next_err = err;
        wr_en = 1'b0;
        wr_addr = 8'h0;
        if (exec_done_pulse) begin
            next_ready = 1'b1;
            next_err = exec_err_in;
            if (exec_len_err_in) begin
                next_err = tcp_pkg::ERR_COUNT;
            end
            if (cmd == 8'h03 && exec_err_in == tcp_pkg::ERR_NONE) begin
                next_hs = 1'b1;
            end
        end
        if (!bus_on || stop_c) begin
            next_st = tcp_pkg::ST_IDLE;
            next_o_sda = 1'b0;
        end else if (start_c) begin
            next_st = tcp_pkg::ST_ADDR;
            next_bit_n = 4'h0;
            next_o_sda = 1'b0;
        end else begin
            unique case (st)
                tcp_pkg::ST_IDLE, tcp_pkg::ST_SKIP: begin
                end
                tcp_pkg::ST_ADDR, tcp_pkg::ST_RX: begin
                    if (rise) begin
                        next_sh = {sh[6:0], sda};
                        next_bit_n = bit_n + 4'h1;
                    end
                    if (fall && bit_n == 4'h8) begin
                        next_st = tcp_pkg::ST_ACK;
                        next_ack = 1'b1;
                        if (st == tcp_pkg::ST_ADDR) begin
                            next_rd = sh[tcp_pkg::ADDR_RW_BIT];
                            next_stat = sh[tcp_pkg::ADDR_SEL_BIT];
                            next_idx = 9'h0;
                            if (sh[7:2] != dev_addr_in[7:2]) begin
                                next_ack = 1'b0;
                            end else if (!sh[tcp_pkg::ADDR_SEL_BIT] && busy) begin
                                next_ack = 1'b0;
                            end else if (sh[tcp_pkg::ADDR_SEL_BIT] && !sh[tcp_pkg::ADDR_RW_BIT]) begin
                                next_ack = 1'b0;
                            end
                        end else if (idx == 9'h0) begin
                            next_cmd = sh;
                            next_idx = 9'h1;
                            // Illegal ordinal locks at once; no count byte is awaited
                            if (sh >= tcp_pkg::CMD_ILLEGAL) begin
                                next_ready = 1'b0;
                                next_go = 1'b1;
                            end
                        end else if (idx == 9'h1) begin
                            next_cnt = sh;
                            next_idx = 9'h2;
                            if (sh == 8'h0) begin
                                next_ready = 1'b0;
                                next_go = 1'b1;
                            end
                        end else if (idx <= {1'b0, cnt} + 9'h1) begin
                            wr_en = 1'b1;
                            wr_addr = 8'(idx - 9'h2);
                            next_idx = idx + 9'h1;
                            if (idx == {1'b0, cnt} + 9'h1) begin
                                next_ready = 1'b0;
                                next_go = 1'b1;
                            end
                        end
                        next_o_sda = next_ack;
                    end
                end
                tcp_pkg::ST_ACK: begin
                    if (fall) begin
                        next_bit_n = 4'h0;
                        next_o_sda = 1'b0;
                        if (!ack) begin
                            next_st = tcp_pkg::ST_SKIP;
                        end else if (rd) begin
                            next_st = tcp_pkg::ST_TX;
                            next_sh = tx_byte;
                            next_o_sda = ~tx_byte[7];
                        end else begin
                            next_st = tcp_pkg::ST_RX;
                        end
                    end
                end
                tcp_pkg::ST_TX: begin
                    if (fall) begin
                        next_bit_n = bit_n + 4'h1;
                        next_sh = {sh[6:0], 1'b0};
                        next_o_sda = ~sh[6];
                        if (bit_n == 4'h7) begin
                            next_st = tcp_pkg::ST_TACK;
                            next_o_sda = 1'b0;
                            next_idx = (idx <= {1'b0, cnt}) ? idx + 9'h1 : idx;
                        end
                    end
                end
                tcp_pkg::ST_TACK: begin
                    if (rise) begin
                        next_ack = ~sda;
                    end
                    if (fall) begin
                        next_bit_n = 4'h0;
                        if (ack) begin
                            next_st = tcp_pkg::ST_TX;
                            next_sh = tx_byte;
                            next_o_sda = ~tx_byte[7];
                        end else begin
                            next_st = tcp_pkg::ST_SKIP;
                        end
                    end
                end
                default: begin
                    next_st = tcp_pkg::ST_IDLE;
                end
            endcase
        end
    end
    always_ff @(posedge mclk_in) begin
        if (wr_en) begin
            buf_mem[wr_addr] <= sh;
        end
    end
    // Sda is only ever pulled low; scl is never driven (no stretching).
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            st <= tcp_pkg::ST_IDLE;
            sh <= 8'h0;
            bit_n <= 4'h0;
            idx <= 9'h0;
            rd <= 1'b0;
            stat <= 1'b0;
            ack <= 1'b0;
            o_sda <= 1'b0;
            cmd <= 8'h0;
            cnt <= 8'h0;
            go <= 1'b0;
            ready <= 1'b0;
            hs <= 1'b0;
            err <= tcp_pkg::ERR_NONE;
            hold <= 32'h0;
            rst_seen <= 2'h0;
            pen <= 1'b0;
            exec <= 1'b0;
            exec_cnt <= 32'h0;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
            sda_out <= 1'b0;
            sda_oe_out <= 1'b0;
            cmd_out <= 8'h0;
            count_out <= 8'h0;
            exec_start_out <= 1'b0;
            output_ready_flag <= 1'b0;
            handshake_complete_flag <= 1'b0;
            busy_out <= 1'b1;
            asleep_out <= 1'b0;
        end else begin
            st <= next_st;
            sh <= next_sh;
            bit_n <= next_bit_n;
            idx <= next_idx;
            rd <= next_rd;
            stat <= next_stat;
            ack <= next_ack;
            o_sda <= next_o_sda;
            cmd <= next_cmd;
            cnt <= next_cnt;
            go <= next_go;
            ready <= next_ready;
            hs <= next_hs;
            err <= next_err;
            hold <= next_hold;
            rst_seen <= next_rst_seen;
            pen <= next_pen;
            exec <= next_exec;
            exec_cnt <= next_exec_cnt;
            scl_d <= scl;
            sda_d <= sda;
            sda_out <= 1'b0;
            sda_oe_out <= next_o_sda;
            cmd_out <= next_cmd;
            count_out <= next_cnt;
            exec_start_out <= next_go && next_cmd < tcp_pkg::CMD_ILLEGAL;
            output_ready_flag <= next_ready;
            handshake_complete_flag <= next_hs;
            busy_out <= next_exec | next_pen | (next_hold != 32'h0);
            asleep_out <= slp_s;
        end
    end
    // ****************************************
    // Checks
    // ****************************************
    a_sleep_quiet: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        slp_s |=> !sda_oe_out) else $error("bus driven while asleep");
    a_mismatch_nack: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (st == tcp_pkg::ST_ADDR && fall && bit_n == 4'h8 && sh[7:2] != dev_addr_in[7:2] && bus_on)
        |=> !ack) else $error("address mismatch acked");
    a_busy_nack: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (st == tcp_pkg::ST_ADDR && fall && bit_n == 4'h8 && !sh[1] && busy && bus_on)
        |=> !ack) else $error("command path acked while busy");
    a_illegal_lock: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        (go && cmd >= tcp_pkg::CMD_ILLEGAL) |=> pen && !exec_start_out) else $error("illegal ordinal ran");
    a_status_zero: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        status[4:3] == 2'h0 && status[1] == busy) else $error("status layout wrong");
    a_no_wake_bus: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $fell(slp_s) |-> !bus_on [*8]) else $error("bus accepted right after wake");
    a_start_busy: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        $rose(rst_seen[0]) |-> busy) else $error("ready before startup wait");
    a_go_clears: assert property (@(posedge mclk_in) disable iff (!rst_b_in)
        next_go |=> !output_ready_flag) else $error("ready not cleared by new command");
    c_cmd_go: cover property (@(posedge mclk_in) exec_start_out);
    c_status_rd: cover property (@(posedge mclk_in) st == tcp_pkg::ST_TX && stat);
    c_penalty: cover property (@(posedge mclk_in) pen);
endmodule
`default_nettype wire

// ===== common/tcp_pkg.sv
// Constants shared by the two-wire command packet slave.
// Assumes a 100 MHz core clock; tcp_slave takes its default timer lengths from it, and the bench uses CMD_ILLEGAL.
package tcp_pkg;
    localparam int CLK_MHZ = 100;
    localparam int START_WAIT_MS = 60;
    localparam int WAKE_WAIT_MS = 50;
    localparam int EXEC_MAX_MS = 20;
    localparam int START_WAIT_CYC = START_WAIT_MS * 1000 * CLK_MHZ;
    localparam int WAKE_WAIT_CYC = WAKE_WAIT_MS * 1000 * CLK_MHZ;
    localparam int EXEC_MAX_CYC = EXEC_MAX_MS * 1000 * CLK_MHZ;
    localparam logic [7:0] ADDR_DEFAULT = 8'hC0;
    localparam logic [7:0] CMD_ILLEGAL = 8'h15;
    localparam int ADDR_SEL_BIT = 1;
    localparam int ADDR_RW_BIT = 0;
    localparam int BUF_DEPTH = 256;
    localparam int FILT_LEN = 3;
    localparam logic [2:0] ERR_NONE = 3'h0;
    localparam logic [2:0] ERR_COUNT = 3'h1;
    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ADDR = 4'h1,
        ST_ACK = 4'h3,
        ST_RX = 4'h2,
        ST_TX = 4'h6,
        ST_TACK = 4'h7,
        ST_SKIP = 4'h5
    } tcp_state_type;
endpackage

// ===== hw/tcp_sync.sv
// Three-flop synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to mclk_in.
`timescale 1ns/100ps
`default_nettype none
module tcp_sync (
    input wire logic mclk_in,
    input wire logic rst_b_in,
    input wire logic pin_in,
    output logic level_out
);
    logic [2:0] sh;
    logic next_level;
    always_comb begin
        next_level = level_out;
        if (sh[1] == sh[2]) begin
            next_level = sh[2];
        end
    end
    always_ff @(posedge mclk_in) begin
        if (!rst_b_in) begin
            sh <= 3'h7;
            level_out <= 1'b1;
        end else begin
            sh <= {sh[1:0], pin_in};
            level_out <= next_level;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/tcp_host_model.sv
// Behavioural two-wire bus master for the command packet slave bench.
// Assumes the bench resolves the data line with a pull-up from both pull-low enables.
`timescale 1ns/100ps
`default_nettype none
module tcp_host_model (
    output logic scl_out,
    output logic sda_low_out,
    input wire logic sda_in
);
    // ********
    // Bit timing
    // ********
    // 31.2 ns quarter bit: no host edge ever lands on a rising core clock edge
    // Bench runs far above the real bus limit to keep the run short
    localparam realtime QTR = 31.2;
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    // Clock stands high between frames and only the host drives it
    task automatic bus_start();
        sda_low_out = 1'b0;
        #QTR scl_out = 1'b1;
        #QTR sda_low_out = 1'b1;
        #QTR scl_out = 1'b0;
    endtask
    task automatic bus_stop();
        #QTR sda_low_out = 1'b1;
        #QTR scl_out = 1'b1;
        #QTR sda_low_out = 1'b0;
        #QTR;
    endtask
    task automatic bit_cycle(input logic b, output logic r);
        #QTR sda_low_out = !b;
        #QTR scl_out = 1'b1;
        #QTR r = sda_in;
        #QTR scl_out = 1'b0;
    endtask
    // MSB first; ack_out high when the slave pulled the ninth bit low
    task automatic send_byte(input logic [7:0] v, output logic ack_out);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(v[i], r);
        end
        bit_cycle(1'b1, r);
        ack_out = !r;
    endtask
    task automatic get_byte(input logic ack_in, output logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, r);
            v[i] = r;
        end
        bit_cycle(!ack_in, r);
    endtask
endmodule
`default_nettype wire

// ===== testbench/tcp_slave_tb.sv
// Self-checking bench for the two-wire command packet slave.
// Assumes the host model as bus master and the bench as command engine.
`timescale 1ns/100ps
`default_nettype none
module tcp_slave_tb;
    // Short waits keep the run small; expectations use the same values
    localparam int START_N = 1000, WAKE_N = 1000, EXEC_N = 4000, PEN_N = 600, LIMIT = 90000;
    logic mclk_in = 1'b0, rst_b_in = 1'b0, sleep_request_in = 1'b0, exec_done_in = 1'b0, exec_len_err_in = 1'b0;
    logic [7:0] dev_addr_in = 8'hC0;
    logic [2:0] exec_err_in = 3'h0;
    logic sda_out, sda_oe_out, exec_start_out, output_ready_flag, handshake_complete_flag, busy_out, asleep_out;
    logic [7:0] cmd_out, count_out, a;
    logic scl, sda_low, sda_wire, ack;
    int n_errors = 0, n_compared = 0, n_starts = 0, cyc = 0;
    int exp_ready = 0, exp_busy = 1, exp_hs = 0, exp_err = 0;
    logic [7:0] ops[$];
    // ********
    // Bus, clock and instances
    // ********
    assign sda_wire = !(sda_low || (sda_oe_out && !sda_out));
    initial forever #5 mclk_in = !mclk_in;
    tcp_host_model host (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_wire));
    tcp_slave #(.START_CYC(START_N), .WAKE_CYC(WAKE_N), .EXEC_CYC(EXEC_N), .PENALTY_CYC(PEN_N)) dut (
        .mclk_in(mclk_in), .rst_b_in(rst_b_in), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out),
        .sda_oe_out(sda_oe_out), .sleep_request_in(sleep_request_in), .dev_addr_in(dev_addr_in),
        .exec_done_in(exec_done_in), .exec_err_in(exec_err_in), .exec_len_err_in(exec_len_err_in),
        .cmd_out(cmd_out), .count_out(count_out), .exec_start_out(exec_start_out),
        .output_ready_flag(output_ready_flag), .handshake_complete_flag(handshake_complete_flag),
        .busy_out(busy_out), .asleep_out(asleep_out));
    always @(posedge mclk_in) begin
        cyc <= cyc + 1;
        if (exec_start_out === 1'b1) n_starts <= n_starts + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            tally_and_finish();
        end
    end
    // ********
    // Checking and transfer tasks
    // ********
    task automatic tally_and_finish();
        $display("Compared %0d, errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic check_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t bit got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
        end
    endtask
    function automatic logic [7:0] exp_status();
        return {exp_err[2:0], 2'b00, exp_hs[0], exp_busy[0], exp_ready[0]};
    endfunction
    task automatic status_read(input logic exp_ack);
        logic [7:0] s;
        host.bus_start();
        host.send_byte({dev_addr_in[7:2], 2'b11}, ack);
        check_bit(ack, exp_ack);
        if (ack) begin
            host.get_byte(1'b0, s);
            check_byte(s, exp_status());
        end
        host.bus_stop();
    endtask
    task automatic cmd_write(input logic [7:0] ord, input logic exp_ack);
        host.bus_start();
        host.send_byte({dev_addr_in[7:2], 2'b00}, ack);
        check_bit(ack, exp_ack);
        if (ack) begin
            host.send_byte(ord, ack);
            if (ord < tcp_pkg::CMD_ILLEGAL) begin
                host.send_byte(8'(ops.size()), ack);
                foreach (ops[i]) host.send_byte(ops[i], ack);
                check_bit(ack, 1'b1);
            end
        end
        host.bus_stop();
    endtask
    task automatic cmd_read();
        logic [7:0] v;
        host.bus_start();
        host.send_byte({dev_addr_in[7:2], 2'b01}, ack);
        check_bit(ack, 1'b1);
        host.get_byte(ops.size() != 0, v);
        check_byte(v, 8'(ops.size()));
        foreach (ops[i]) begin
            host.get_byte(i < ops.size() - 1, v);
            check_byte(v, ops[i]);
        end
        host.bus_stop();
    endtask
    task automatic run_cmd(input logic [7:0] ord, input logic [2:0] err, input logic len_err);
        int prev;
        int k;
        ops = {};
        repeat ($urandom_range(0, 3)) ops.push_back(8'($urandom));
        prev = n_starts;
        cmd_write(ord, 1'b1);
        k = 0;
        while (n_starts == prev && k < 300) begin
            @(negedge mclk_in);
            k++;
        end
        @(negedge mclk_in);
        check_bit(n_starts != prev, 1'b1);
        check_byte(cmd_out, ord);
        check_byte(count_out, 8'(ops.size()));
        exp_busy = 1;
        exp_ready = 0;
        check_bit(busy_out, 1'b1);
        cmd_write(ord, 1'b0);
        status_read(1'b1);
        @(negedge mclk_in);
        exec_err_in = err;
        exec_len_err_in = len_err;
        exec_done_in = 1'b1;
        @(negedge mclk_in);
        exec_done_in = 1'b0;
        @(negedge mclk_in);
        exp_busy = 0;
        exp_ready = 1;
        exp_err = len_err ? 1 : int'(err);
        if (ord == 8'h03 && exp_err == 0) exp_hs = 1;
        check_bit(output_ready_flag, 1'b1);
        check_bit(handshake_complete_flag, exp_hs[0]);
        status_read(1'b1);
        cmd_read();
        cmd_read();
    endtask
    // ********
    // Main sequence
    // ********
    initial begin
        void'($urandom(92582));
        repeat (3) @(negedge mclk_in);
        rst_b_in = 1'b1;
        @(negedge mclk_in);
        check_bit(busy_out, 1'b1);
        // The whole bus stays shut during the startup wait
        status_read(1'b0);
        cmd_write(8'h01, 1'b0);
        repeat (START_N) @(negedge mclk_in);
        exp_busy = 0;
        status_read(1'b1);
        for (int k = 0; k < 4; k++) begin
            a = 8'($urandom);
            if (a[7:2] == 6'h30) a[2] = 1'b1;
            host.bus_start();
            host.send_byte(a, ack);
            check_bit(ack, 1'b0);
            host.bus_stop();
        end
        @(negedge mclk_in);
        dev_addr_in = 8'($urandom);
        status_read(1'b1);
        @(negedge mclk_in);
        dev_addr_in = 8'hC0;
        host.bus_start();
        host.send_byte(8'hC2, ack);
        check_bit(ack, 1'b0);
        host.bus_stop();
        run_cmd(8'($urandom_range(4, 20)), 3'($urandom), 1'b0);
        run_cmd(8'h03, 3'h0, 1'b0);
        run_cmd(8'($urandom_range(1, 2)), 3'($urandom), 1'b1);
        a = 8'($urandom_range(21, 255));
        cmd_write(a, 1'b1);
        repeat (5) @(negedge mclk_in);
        check_bit(busy_out, 1'b1);
        cmd_write(8'h01, 1'b0);
        repeat (PEN_N) @(negedge mclk_in);
        check_bit(busy_out, 1'b0);
        run_cmd(8'($urandom_range(4, 20)), 3'h0, 1'b0);
        @(negedge mclk_in);
        sleep_request_in = 1'b1;
        repeat (5) @(negedge mclk_in);
        check_bit(asleep_out, 1'b1);
        status_read(1'b0);
        @(negedge mclk_in);
        sleep_request_in = 1'b0;
        status_read(1'b0);
        repeat (WAKE_N) @(negedge mclk_in);
        status_read(1'b1);
        sleep_request_in = 1'b1;
        rst_b_in = 1'b0;
        repeat (3) @(negedge mclk_in);
        rst_b_in = 1'b1;
        sleep_request_in = 1'b0;
        @(negedge mclk_in);
        check_bit(output_ready_flag, 1'b0);
        check_bit(handshake_complete_flag, 1'b0);
        check_bit(busy_out, 1'b1);
        {exp_ready, exp_hs, exp_err, exp_busy} = {32'd0, 32'd0, 32'd0, 32'd0};
        repeat (START_N + WAKE_N) @(negedge mclk_in);
        status_read(1'b1);
        tally_and_finish();
    end
endmodule
`default_nettype wire
